// *** hdl/gpel_defines.vh ***
`ifndef GPEL_DEFINES_VH
`define GPEL_DEFINES_VH
`define GPEL_OFS_STATUS        8'ha8
`define GPEL_OFS_ENABLE        8'haa
`define GPEL_RESET_VALUE       16'h0000
`define GPEL_IMPL_MASK         16'hc91f
`define GPEL_BIT_SOCKET0_VIDEO 15
`define GPEL_BIT_SOCKET1_VIDEO 14
`define GPEL_BIT_POWER         11
`define GPEL_BIT_HIGH_PROG     8
`define GPEL_VIDEO_PORT_BIT    6
`define GPEL_PROG_12V_CODE     2'h2
`define GPEL_INPUT_COUNT       5
`endif

// *** hdl/gpel_event_logic.v ***
`timescale 1ns/100ps
`include "gpel_defines.vh"
module gpel_event_logic #(
  parameter NUM_INPUTS = `GPEL_INPUT_COUNT
) (
  input  wire                  sys_clk,
  input  wire                  rst,
  input  wire                  cfg_function0,
  input  wire                  cfg_write,
  input  wire                  cfg_read,
  input  wire [7:0]            cfg_addr,
  input  wire [15:0]           cfg_wdata,
  input  wire [1:0]            cfg_byte_en,
  output reg  [15:0]           cfg_rdata,
  input  wire [7:0]            socket0_card_control,
  input  wire [7:0]            socket1_card_control,
  input  wire [3:0]            socket0_power_select,
  input  wire [3:0]            socket1_power_select,
  input  wire [NUM_INPUTS-1:0] general_input_pins,
  input  wire [NUM_INPUTS-1:0] input_configured,
  input  wire                  event_pin_configured,
  output reg                   system_event_out_n,
  output reg                   system_event_oe_n
);

  reg [NUM_INPUTS-1:0] sync_stage1;
  reg [NUM_INPUTS-1:0] sync_stage2;
  reg [NUM_INPUTS-1:0] input_last;
  reg                  video0_last;
  reg                  video1_last;
  reg [3:0]            power0_last;
  reg [3:0]            power1_last;
  reg                  history_valid;
  reg [15:0]           event_status_flags;
  reg [15:0]           event_enable_mask;
  reg [15:0]           set_events;
  reg [15:0]           clear_bits;
  reg [15:0]           write_mask;
  reg [15:0]           pending;
  reg [15:0]           next_status;
  reg [15:0]           next_rdata;
  wire                 access_ok;

  function is_12v;
    input [3:0] sel;
    begin
      is_12v = (sel[1:0] == `GPEL_PROG_12V_CODE);
    end
  endfunction

  assign access_ok = cfg_function0;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_stage1   <= {NUM_INPUTS{1'b0}};
      sync_stage2   <= {NUM_INPUTS{1'b0}};
      input_last    <= {NUM_INPUTS{1'b0}};
      video0_last   <= 1'b0;
      video1_last   <= 1'b0;
      power0_last   <= 4'h0;
      power1_last   <= 4'h0;
      history_valid <= 1'b0;
    end else begin
      sync_stage1   <= general_input_pins;
      sync_stage2   <= sync_stage1;
      input_last    <= sync_stage2;
      video0_last   <= socket0_card_control[`GPEL_VIDEO_PORT_BIT];
      video1_last   <= socket1_card_control[`GPEL_VIDEO_PORT_BIT];
      power0_last   <= socket0_power_select;
      power1_last   <= socket1_power_select;
      history_valid <= 1'b1;
    end
  end

  always @* begin
    set_events = 16'h0000;
    if (history_valid) begin
      set_events[`GPEL_BIT_SOCKET0_VIDEO] =
        socket0_card_control[`GPEL_VIDEO_PORT_BIT] ^ video0_last;
      set_events[`GPEL_BIT_SOCKET1_VIDEO] =
        socket1_card_control[`GPEL_VIDEO_PORT_BIT] ^ video1_last;
      set_events[`GPEL_BIT_POWER] = (socket0_power_select != power0_last) ||
                                    (socket1_power_select != power1_last);
      set_events[`GPEL_BIT_HIGH_PROG] = (is_12v(socket0_power_select) != is_12v(power0_last)) ||
                                        (is_12v(socket1_power_select) != is_12v(power1_last));
      set_events[NUM_INPUTS-1:0] = sync_stage2 ^ input_last;
    end
  end

  always @* begin
    write_mask = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} & `GPEL_IMPL_MASK;
    clear_bits = 16'h0000;
    if (cfg_write && access_ok && cfg_addr == `GPEL_OFS_STATUS)
      clear_bits = cfg_wdata & write_mask;
    // a new event in the clearing cycle wins
    next_status = ((event_status_flags & ~clear_bits) | set_events) & `GPEL_IMPL_MASK;
    pending = event_status_flags & event_enable_mask;
    pending[NUM_INPUTS-1:0] = pending[NUM_INPUTS-1:0] & input_configured;
    next_rdata = 16'h0000;
    if (cfg_read && access_ok) begin
      case (cfg_addr)
        `GPEL_OFS_STATUS: next_rdata = event_status_flags;
        `GPEL_OFS_ENABLE: next_rdata = event_enable_mask;
        default:          next_rdata = 16'h0000;
      endcase
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      event_status_flags <= `GPEL_RESET_VALUE;
      event_enable_mask  <= `GPEL_RESET_VALUE;
      cfg_rdata          <= 16'h0000;
      system_event_out_n <= 1'b1;
      system_event_oe_n  <= 1'b1;
    end else begin
      event_status_flags <= next_status;
      if (cfg_write && access_ok && cfg_addr == `GPEL_OFS_ENABLE)
        event_enable_mask <= (event_enable_mask & ~write_mask) | (cfg_wdata & write_mask);
      cfg_rdata          <= next_rdata;
      system_event_out_n <= ~(|pending);
      system_event_oe_n  <= ~event_pin_configured;
    end
  end

endmodule // gpel_event_logic

// *** bench/gpel_props.sv ***
`timescale 1ns/100ps
module gpel_props (
  input logic        sys_clk, rst, cfg_function0, cfg_write, cfg_read, event_pin_configured,
  input logic        system_event_out_n, system_event_oe_n,
  input logic [1:0]  cfg_byte_en,
  input logic [7:0]  cfg_addr, socket0_card_control, socket1_card_control,
  input logic [15:0] cfg_wdata, cfg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wr = cfg_write & cfg_function0;
  wire rs = cfg_read & cfg_function0 & (cfg_addr == 8'ha8);
  wire re = cfg_read & cfg_function0 & (cfg_addr == 8'haa);
  property p_rsv; cfg_read |=> !(cfg_rdata & 16'h36e0); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_fn; cfg_read && !cfg_function0 |=> !cfg_rdata; endproperty
  a_fn: assert property (p_fn) else $error("second function read");
  property p_en; wr && cfg_addr == 8'haa && &cfg_byte_en ##1 !wr ##1 re |=> cfg_rdata == ($past(cfg_wdata, 3) & 16'hc91f); endproperty
  a_en: assert property (p_en) else $error("enable read back");
  property p_oe; !event_pin_configured |=> system_event_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("event pin driven");
  property p_on; event_pin_configured |=> !system_event_oe_n; endproperty
  a_on: assert property (p_on) else $error("event pin released");
  property p_hold; !system_event_out_n && !wr && !$past(wr) |=> !system_event_out_n; endproperty
  a_hold: assert property (p_hold) else $error("event dropped");
  property p_v0; $changed(socket0_card_control[6]) ##1 !wr ##1 rs |=> cfg_rdata[15]; endproperty
  a_v0: assert property (p_v0) else $error("socket0 flag");
  property p_v1; $changed(socket1_card_control[6]) ##1 !wr ##1 rs |=> cfg_rdata[14]; endproperty
  a_v1: assert property (p_v1) else $error("socket1 flag");
endmodule // gpel_props
bind gpel_event_logic gpel_props u_props (.*);

// *** bench/gpel_host_model.sv ***
`timescale 1ns/100ps
module gpel_host_model (
  input  logic system_event_out_n,
  input  logic system_event_oe_n,
  output logic host_event
);
  // pulled-up line, so a released pin reads high
  assign host_event = system_event_oe_n ? 1'b1 : system_event_out_n;
endmodule // gpel_host_model

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk = 0, rst = 1, cfg_function0 = 1, cfg_write = 0, cfg_read = 0, event_pin_configured = 1;
  logic [7:0]  cfg_addr = 8'ha8, socket0_card_control = 8'h00, socket1_card_control = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata;
  logic [3:0]  socket0_power_select = 4'h0, socket1_power_select = 4'h0;
  logic [4:0]  general_input_pins = 5'h00, input_configured = 5'h1e;
  logic [1:0]  cfg_byte_en = 2'h3;
  logic        system_event_out_n, system_event_oe_n, host_event;
  int          err_count = 0, cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  gpel_event_logic dut (.*);
  gpel_host_model host (.*);
  task automatic chk(string n, logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  // one access: w=1 writes d, w=0 reads and expects d
  task automatic acc(logic w, logic [7:0] a, logic [15:0] d, logic f = 1);
    @(posedge sys_clk) {cfg_write, cfg_read, cfg_addr, cfg_wdata, cfg_function0} <= {w, !w, a, d, f};
    @(posedge sys_clk) {cfg_write, cfg_read} <= 2'h0;
    #1 if (!w) chk("rdata", cfg_rdata, d);
  endtask
  task automatic ev(logic v);
    repeat (2) @(posedge sys_clk);
    #1 chk("event", host_event, v);
  endtask
  task automatic t_regs;
    acc(0, 8'ha8, 16'h0000, 0);
    acc(1, 8'haa, 16'hffff, 0);
    acc(0, 8'haa, 16'h0000);
    acc(1, 8'haa, 16'hffff);
    acc(0, 8'haa, 16'hc91f);
    acc(1, 8'haa, 16'h0000);
  endtask
  task automatic t_flags;
    repeat (2) begin
      @(posedge sys_clk) socket0_card_control <= socket0_card_control ^ 8'h40;
      socket1_card_control <= socket1_card_control ^ 8'h40;
      socket0_power_select <= socket0_power_select ^ 4'h2;
      @(posedge sys_clk);
      acc(0, 8'ha8, 16'hc900);
      acc(1, 8'ha8, 16'hffff);
      acc(0, 8'ha8, 16'h0000);
    end
  endtask
  task automatic t_pins;
    acc(1, 8'haa, 16'h0001);
    @(posedge sys_clk) general_input_pins <= 5'h1f;
    repeat (6) @(posedge sys_clk);
    acc(0, 8'ha8, 16'h001f);
    ev(1);
    acc(1, 8'haa, 16'h0011);
    ev(0);
    @(posedge sys_clk) event_pin_configured <= 0;
    ev(1);
    @(posedge sys_clk) event_pin_configured <= 1;
    ev(0);
    acc(1, 8'ha8, 16'h0010);
    ev(1);
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk) #1 t_regs;
    t_flags;
    t_pins;
    end_of_test;
  end
endmodule // tb_top
